/* File: logic/rpic_device.sv */
`timescale 1ns/1ps
// Overview of operation
// - Rate field divides master clock 1024/768/640/512.
// - Selector and partition bits choose control mode.
// - Three modes, only in host-interface mode.
// - Direct mode stores host addresses unchanged.
// - Fixed mode generates equal shares per track.
// - Flex mode chains tracks, no fixed capacity.
// - Eight-track layouts decode three bits binary.
// - Four/two-track layouts use top select bits.
// - Begin address 12 bits, end 20 bits.
// - Host keeps rows within 008h to FFFh.
// - Host keeps tail column within width limit.
// - Eight nibbles: end low first, begin last.
// - Host checks busy or waits per nibble.
// - Each read strobe returns next address nibble.
// - Host waits busy time after final strobe.
// - No status on bus during index read.
// - Width bit selects 3-bit or 4-bit coding.
// - Busy raised while processing; commands refused.
// - Busy 270us after index write or index read command, 50us per nibble.
// - 50us after each read nibble, busy hidden except after the last.
module rpic_device #(
   parameter logic [14:0] LONG_BUSY_CYC = rpic_pkg::BUSY_LONG_CYC,
   parameter logic [14:0] NIBBLE_BUSY_CYC = rpic_pkg::BUSY_NIBBLE_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   rpic_if.dev bus,
   input wire logic host_if_mode,
   output logic sample_tick,
   output logic [1:0] rate_sel,
   output rpic_pkg::rpic_mode_e ctrl_mode,
   output logic [2:0] track_num,
   output logic code_bits_4,
   output logic busy
);
   typedef enum logic [1:0] {
      ST_CMD = 2'b00,
      ST_ARG = 2'b01,
      ST_IDX_WR = 2'b10,
      ST_IDX_RD = 2'b11
   } rpic_state_e;

   rpic_state_e state_q;
   logic [3:0] pend_cmd_q;
   logic [2:0] nib_cnt_q;
   logic [14:0] busy_cnt_q;
   logic [31:0] shift_q;
   logic [31:0] idx_q [rpic_pkg::TRACKS];
   logic [1:0] rate_q;
   logic [1:0] part_q;
   logic auto_q;
   logic [2:0] track_bits_q;
   logic width_q;
   logic [10:0] div_cnt_q;
   logic tick_q;
   logic [3:0] dout_q;
   logic dout_oe_n_q;
   logic wr_take;
   logic rd_idx_take;
   logic rd_status_take;
   logic last_nibble;
   logic [3:0] nib_in;
   rpic_pkg::rpic_mode_e mode_now;
   rpic_pkg::rpic_mode_e mode_new;
   logic [2:0] track_new;
   logic [31:0] gen_entry;

   function automatic rpic_pkg::rpic_mode_e mode_of(input logic auto_sel,
                                                     input logic [1:0] part,
                                                     input logic host_mode);
      rpic_pkg::rpic_mode_e m;
      m = rpic_pkg::RPIC_DIRECT;
      if (host_mode && auto_sel) begin
         case (part)
            2'b00: m = rpic_pkg::RPIC_FIXED8;
            2'b01: m = rpic_pkg::RPIC_FIXED4;
            2'b10: m = rpic_pkg::RPIC_FIXED2;
            2'b11: m = rpic_pkg::RPIC_FLEX8;
            default: m = rpic_pkg::RPIC_DIRECT;
         endcase
      end
      return m;
   endfunction : mode_of

   function automatic logic [2:0] track_of(input rpic_pkg::rpic_mode_e m,
                                           input logic [2:0] bits);
      logic [2:0] t;
      t = bits;
      if (m == rpic_pkg::RPIC_FIXED4) begin
         t = {1'b0, bits[2:1]};
      end else if (m == rpic_pkg::RPIC_FIXED2) begin
         t = {2'b00, bits[2]};
      end
      return t;
   endfunction : track_of

   function automatic logic [10:0] divisor_of(input logic [1:0] rate);
      logic [10:0] d;
      case (rate)
         2'b00: d = rpic_pkg::DIV_00;
         2'b01: d = rpic_pkg::DIV_01;
         2'b10: d = rpic_pkg::DIV_10;
         2'b11: d = rpic_pkg::DIV_11;
         default: d = rpic_pkg::DIV_00;
      endcase
      return d;
   endfunction : divisor_of

   assign mode_now = mode_of(auto_q, part_q, host_if_mode);
   assign nib_in = bus.data;
   assign busy = (busy_cnt_q != 15'h0000);
   // Nibbles are refused while busy, so a host that skips the wait loses data silently.
   assign wr_take = host_if_mode && !bus.wr_n && !busy && (state_q != ST_IDX_RD);
   assign rd_idx_take = !bus.rd_n && !busy && (state_q == ST_IDX_RD);
   assign rd_status_take = !bus.rd_n && (state_q != ST_IDX_RD);
   assign last_nibble = (nib_cnt_q == 3'(rpic_pkg::IDX_NIBBLES - 1));
   assign mode_new = mode_of(nib_in[rpic_pkg::AUTO_POS], part_q, host_if_mode);
   assign track_new = track_of(mode_new, nib_in[rpic_pkg::TRACK_LSB +: 3]);

   // Address generation for a track selected in fixed or flex mode.
   always_comb begin
      logic [11:0] share;
      logic [11:0] begin_row;
      logic [11:0] end_row;
      logic [11:0] prev_end_row;
      logic [7:0] tail;
      share = rpic_pkg::ROW_SPAN >> 3;
      begin_row = rpic_pkg::ROW_FIRST;
      end_row = rpic_pkg::ROW_LAST;
      prev_end_row = rpic_pkg::ROW_FIRST;
      tail = width_q ? rpic_pkg::TAIL_COL_4BIT : rpic_pkg::TAIL_COL_3BIT;
      if (track_new != 3'h0) begin
         prev_end_row = idx_q[track_new - 3'h1][rpic_pkg::END_W-1:8];
      end
      case (mode_new)
         rpic_pkg::RPIC_FIXED4: share = rpic_pkg::ROW_SPAN >> 2;
         rpic_pkg::RPIC_FIXED2: share = rpic_pkg::ROW_SPAN >> 1;
         default: share = rpic_pkg::ROW_SPAN >> 3;
      endcase
      if (mode_new == rpic_pkg::RPIC_FLEX8) begin
         if (track_new != 3'h0) begin
            begin_row = prev_end_row + 12'h001;
         end
         end_row = rpic_pkg::ROW_LAST;
      end else begin
         begin_row = 12'(rpic_pkg::ROW_FIRST + 12'(track_new) * share);
         end_row = begin_row + share - 12'h001;
      end
      gen_entry = {begin_row, end_row, tail};
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_CMD;
         pend_cmd_q <= 4'h0;
         nib_cnt_q <= 3'h0;
      end else if (wr_take || rd_idx_take) begin
         case (state_q)
            ST_CMD: begin
               pend_cmd_q <= nib_in;
               nib_cnt_q <= 3'h0;
               if (nib_in == rpic_pkg::CMD_RATE || nib_in == rpic_pkg::CMD_TRACK ||
                   nib_in == rpic_pkg::CMD_WIDTH) begin
                  state_q <= ST_ARG;
               end else if (nib_in == rpic_pkg::CMD_IDX_WR) begin
                  state_q <= ST_IDX_WR;
               end else if (nib_in == rpic_pkg::CMD_IDX_RD) begin
                  state_q <= ST_IDX_RD;
               end
            end
            ST_ARG: state_q <= ST_CMD;
            ST_IDX_WR, ST_IDX_RD: begin
               nib_cnt_q <= nib_cnt_q + 3'h1;
               if (last_nibble) begin
                  state_q <= ST_CMD;
               end
            end
            default: state_q <= ST_CMD;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_q <= 15'h0000;
      end else if (wr_take && state_q == ST_CMD &&
                   (nib_in == rpic_pkg::CMD_IDX_WR || nib_in == rpic_pkg::CMD_IDX_RD)) begin
         busy_cnt_q <= LONG_BUSY_CYC;
      end else if ((wr_take && state_q == ST_IDX_WR) || rd_idx_take) begin
         busy_cnt_q <= NIBBLE_BUSY_CYC;
      end else if (wr_take) begin
         busy_cnt_q <= rpic_pkg::BUSY_SHORT_CYC;
      end else if (busy) begin
         busy_cnt_q <= busy_cnt_q - 15'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rate_q <= rpic_pkg::RATE_RESET;
         part_q <= rpic_pkg::PART_RESET;
         auto_q <= 1'b0;
         track_bits_q <= rpic_pkg::TRACK_RESET;
         width_q <= 1'b0;
      end else if (wr_take && state_q == ST_ARG) begin
         case (pend_cmd_q)
            rpic_pkg::CMD_RATE: begin
               rate_q <= nib_in[rpic_pkg::RATE_LSB +: 2];
               part_q <= nib_in[rpic_pkg::PART_LSB +: 2];
            end
            rpic_pkg::CMD_TRACK: begin
               auto_q <= nib_in[rpic_pkg::AUTO_POS];
               track_bits_q <= nib_in[rpic_pkg::TRACK_LSB +: 3];
            end
            rpic_pkg::CMD_WIDTH: width_q <= nib_in[rpic_pkg::WIDTH_POS];
            default: width_q <= width_q;
         endcase
      end
   end

   // One shift register serves both directions; nibble k sits at bits 4k+3..4k.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         shift_q <= rpic_pkg::IDX_RESET;
      end else if (wr_take && state_q == ST_CMD && nib_in == rpic_pkg::CMD_IDX_RD) begin
         shift_q <= idx_q[track_num];
      end else if ((wr_take && state_q == ST_IDX_WR) || rd_idx_take) begin
         shift_q <= {nib_in, shift_q[31:4]};
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < rpic_pkg::TRACKS; i++) begin
            idx_q[i] <= rpic_pkg::IDX_RESET;
         end
      end else if (wr_take && state_q == ST_IDX_WR && last_nibble &&
                   mode_now == rpic_pkg::RPIC_DIRECT) begin
         idx_q[track_num] <= {nib_in, shift_q[31:4]};
      end else if (wr_take && state_q == ST_ARG && pend_cmd_q == rpic_pkg::CMD_TRACK &&
                   mode_new != rpic_pkg::RPIC_DIRECT) begin
         idx_q[track_new] <= gen_entry;
      end
   end

   // Bus drive lasts the cycle after the strobe, where the host samples it.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dout_q <= 4'h0;
         dout_oe_n_q <= 1'b1;
      end else if (rd_idx_take) begin
         dout_q <= shift_q[3:0];
         dout_oe_n_q <= 1'b0;
      end else if (rd_status_take) begin
         dout_q <= 4'(busy) << rpic_pkg::BUSY_POS;
         dout_oe_n_q <= 1'b0;
      end else begin
         dout_oe_n_q <= 1'b1;
      end
   end

   // The divider restarts cleanly when a faster rate lowers the terminal count.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_cnt_q <= 11'h000;
         tick_q <= 1'b0;
      end else if (div_cnt_q >= divisor_of(rate_q) - 11'h001) begin
         div_cnt_q <= 11'h000;
         tick_q <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 11'h001;
         tick_q <= 1'b0;
      end
   end

   assign bus.dev_dout = dout_q;
   assign bus.dev_oe_n = dout_oe_n_q;
   assign sample_tick = tick_q;
   assign rate_sel = rate_q;
   assign ctrl_mode = mode_now;
   assign track_num = track_of(mode_now, track_bits_q);
   assign code_bits_4 = width_q;
endmodule : rpic_device

/* File: logic/rpic_pkg.sv */
package rpic_pkg;
   // Command codes carried in the first nibble.
   localparam logic [3:0] CMD_RATE = 4'h6;
   localparam logic [3:0] CMD_TRACK = 4'h7;
   localparam logic [3:0] CMD_IDX_WR = 4'h8;
   localparam logic [3:0] CMD_IDX_RD = 4'h9;
   localparam logic [3:0] CMD_WIDTH = 4'hC;

   // Argument and status nibble field positions.
   localparam int RATE_LSB = 0;
   localparam int PART_LSB = 2;
   localparam int TRACK_LSB = 0;
   localparam int AUTO_POS = 3;
   localparam int WIDTH_POS = 2;
   localparam int BUSY_POS = 0;

   // Busy times and their cycle counts at the system clock rate.
   localparam int CLK_MHZ = 100;
   localparam int BUSY_SHORT_US = 16;
   localparam int BUSY_LONG_US = 270;
   localparam int BUSY_NIBBLE_US = 50;
   localparam logic [14:0] BUSY_SHORT_CYC = 15'(BUSY_SHORT_US * CLK_MHZ);
   localparam logic [14:0] BUSY_LONG_CYC = 15'(BUSY_LONG_US * CLK_MHZ);
   localparam logic [14:0] BUSY_NIBBLE_CYC = 15'(BUSY_NIBBLE_US * CLK_MHZ);
   localparam logic [14:0] HOST_MARGIN_CYC = 15'h0002;

   // Conversion rate divisors for rate field 00, 01, 10, 11.
   localparam logic [10:0] DIV_00 = 11'h400;
   localparam logic [10:0] DIV_01 = 11'h300;
   localparam logic [10:0] DIV_10 = 11'h280;
   localparam logic [10:0] DIV_11 = 11'h200;

   // Index entry layout: end address in bits 19..0, begin row in bits 31..20.
   localparam int END_W = 20;
   localparam int BEGIN_W = 12;
   localparam int IDX_W = 32;
   localparam int IDX_NIBBLES = 8;
   localparam int TRACKS = 8;
   localparam logic [11:0] ROW_FIRST = 12'h008;
   localparam logic [11:0] ROW_LAST = 12'hFFF;
   localparam logic [11:0] ROW_SPAN = 12'hFF8;
   localparam logic [7:0] TAIL_COL_3BIT = 8'hA9;
   localparam logic [7:0] TAIL_COL_4BIT = 8'h7F;

   // Values after reset.
   localparam logic [1:0] RATE_RESET = 2'h0;
   localparam logic [1:0] PART_RESET = 2'h0;
   localparam logic [2:0] TRACK_RESET = 3'h0;
   localparam logic [31:0] IDX_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      RPIC_DIRECT = 3'b000,
      RPIC_FIXED8 = 3'b001,
      RPIC_FIXED4 = 3'b010,
      RPIC_FIXED2 = 3'b011,
      RPIC_FLEX8 = 3'b100
   } rpic_mode_e;

   typedef enum logic [2:0] {
      RPIC_OP_RATE = 3'b000,
      RPIC_OP_TRACK = 3'b001,
      RPIC_OP_WIDTH = 3'b010,
      RPIC_OP_IDX_WR = 3'b011,
      RPIC_OP_IDX_RD = 3'b100
   } rpic_op_e;
endpackage : rpic_pkg

/* File: logic/rpic_if.sv */
`timescale 1ns/1ps
interface rpic_if;
   logic [3:0] host_dout;
   logic host_oe_n;
   logic [3:0] dev_dout;
   logic dev_oe_n;
   logic wr_n;
   logic rd_n;
   logic [3:0] data;

   // Undriven bus floats high, as with pull-ups on the nibble lines.
   assign data = !host_oe_n ? host_dout : (!dev_oe_n ? dev_dout : 4'hF);

   modport dev (input data, input wr_n, input rd_n, output dev_dout, output dev_oe_n);
   modport host (input data, output host_dout, output host_oe_n, output wr_n, output rd_n);
endinterface : rpic_if

/* File: logic/rpic_host.sv */
`timescale 1ns/1ps
module rpic_host #(
   parameter logic [14:0] LONG_BUSY_CYC = rpic_pkg::BUSY_LONG_CYC,
   parameter logic [14:0] NIBBLE_BUSY_CYC = rpic_pkg::BUSY_NIBBLE_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   rpic_if.host bus,
   input wire logic req_valid,
   output logic req_ready,
   input wire rpic_pkg::rpic_op_e req_op,
   input wire logic [3:0] req_arg,
   input wire logic [31:0] req_index,
   output logic rsp_valid,
   output logic [31:0] rsp_index
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_WAIT = 2'b01,
      H_RD_LOW = 2'b10,
      H_RD_CAP = 2'b11
   } rpic_hstate_e;

   rpic_hstate_e state_q;
   rpic_pkg::rpic_op_e op_q;
   logic [31:0] data_q;
   logic [3:0] left_q;
   logic [14:0] wait_q;
   logic wr_n_q;
   logic rd_n_q;
   logic [3:0] dout_q;
   logic oe_n_q;
   logic rsp_valid_q;
   logic is_idx;

   function automatic logic [3:0] code_of(input rpic_pkg::rpic_op_e op);
      logic [3:0] c;
      case (op)
         rpic_pkg::RPIC_OP_RATE: c = rpic_pkg::CMD_RATE;
         rpic_pkg::RPIC_OP_TRACK: c = rpic_pkg::CMD_TRACK;
         rpic_pkg::RPIC_OP_WIDTH: c = rpic_pkg::CMD_WIDTH;
         rpic_pkg::RPIC_OP_IDX_WR: c = rpic_pkg::CMD_IDX_WR;
         rpic_pkg::RPIC_OP_IDX_RD: c = rpic_pkg::CMD_IDX_RD;
         default: c = rpic_pkg::CMD_RATE;
      endcase
      return c;
   endfunction : code_of

   assign is_idx = (req_op == rpic_pkg::RPIC_OP_IDX_WR) || (req_op == rpic_pkg::RPIC_OP_IDX_RD);
   assign req_ready = (state_q == H_IDLE);

   // Pacing is by timed waits only, since status is hidden during an index read.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= H_IDLE;
         op_q <= rpic_pkg::RPIC_OP_RATE;
         data_q <= rpic_pkg::IDX_RESET;
         left_q <= 4'h0;
         wait_q <= 15'h0000;
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         dout_q <= 4'h0;
         oe_n_q <= 1'b1;
         rsp_valid_q <= 1'b0;
      end else begin
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         rsp_valid_q <= 1'b0;
         case (state_q)
            H_IDLE: begin
               if (req_valid) begin
                  op_q <= req_op;
                  data_q <= (req_op == rpic_pkg::RPIC_OP_IDX_WR) ? req_index : {28'h0, req_arg};
                  left_q <= is_idx ? 4'(rpic_pkg::IDX_NIBBLES) : 4'h1;
                  dout_q <= code_of(req_op);
                  wr_n_q <= 1'b0;
                  oe_n_q <= 1'b0;
                  wait_q <= (is_idx ? LONG_BUSY_CYC : rpic_pkg::BUSY_SHORT_CYC) +
                            rpic_pkg::HOST_MARGIN_CYC;
                  state_q <= H_WAIT;
               end
            end
            H_WAIT: begin
               if (wait_q != 15'h0000) begin
                  wait_q <= wait_q - 15'h0001;
               end else if (left_q == 4'h0) begin
                  rsp_valid_q <= (op_q == rpic_pkg::RPIC_OP_IDX_RD);
                  state_q <= H_IDLE;
               end else if (op_q == rpic_pkg::RPIC_OP_IDX_RD) begin
                  rd_n_q <= 1'b0;
                  state_q <= H_RD_LOW;
               end else begin
                  dout_q <= data_q[3:0];
                  data_q <= {4'h0, data_q[31:4]};
                  wr_n_q <= 1'b0;
                  oe_n_q <= 1'b0;
                  left_q <= left_q - 4'h1;
                  wait_q <= ((op_q == rpic_pkg::RPIC_OP_IDX_WR) ? NIBBLE_BUSY_CYC :
                             rpic_pkg::BUSY_SHORT_CYC) + rpic_pkg::HOST_MARGIN_CYC;
               end
            end
            H_RD_LOW: state_q <= H_RD_CAP;
            H_RD_CAP: begin
               data_q <= {bus.data, data_q[31:4]};
               left_q <= left_q - 4'h1;
               wait_q <= NIBBLE_BUSY_CYC + rpic_pkg::HOST_MARGIN_CYC;
               state_q <= H_WAIT;
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end

   assign bus.host_dout = dout_q;
   assign bus.host_oe_n = oe_n_q;
   assign bus.wr_n = wr_n_q;
   assign bus.rd_n = rd_n_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_index = data_q;
endmodule : rpic_host

/* File: sim/rpic_monitor.sv */
`timescale 1ns/1ps
module rpic_monitor #(
   parameter logic [14:0] LONG_BUSY_CYC = rpic_pkg::BUSY_LONG_CYC,
   parameter logic [14:0] NIBBLE_BUSY_CYC = rpic_pkg::BUSY_NIBBLE_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [3:0] host_dout,
   input wire logic host_oe_n,
   input wire logic [3:0] dev_dout,
   input wire logic dev_oe_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [3:0] data
);
   logic [14:0] wr_gap_q;
   logic [14:0] rd_gap_q;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // The gap counters saturate so a long idle spell never wraps into a false short gap.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_gap_q <= '1;
      end else if (!wr_n) begin
         wr_gap_q <= 15'h0001;
      end else if (wr_gap_q != '1) begin
         wr_gap_q <= wr_gap_q + 15'h0001;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_gap_q <= '1;
      end else if (!rd_n) begin
         rd_gap_q <= 15'h0001;
      end else if (rd_gap_q != '1) begin
         rd_gap_q <= rd_gap_q + 15'h0001;
      end
   end
   property p_bus_host; !host_oe_n |-> data == host_dout; endproperty
   a_bus_host: assert property (p_bus_host) else $error("bus not showing host nibble");
   property p_bus_dev; host_oe_n && !dev_oe_n |-> data == dev_dout; endproperty
   a_bus_dev: assert property (p_bus_dev) else $error("bus not showing device nibble");
   property p_no_clash; !(!host_oe_n && !dev_oe_n); endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive the bus");
   property p_wr_pulse; !wr_n |=> wr_n; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than a cycle");
   property p_wr_data; !wr_n |-> !host_oe_n; endproperty
   a_wr_data: assert property (p_wr_data) else $error("write strobe without data");
   property p_rd_answer; !rd_n |=> !dev_oe_n ##1 dev_oe_n; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read nibble not one cycle");
   property p_dev_cause; $fell(dev_oe_n) |-> !$past(rd_n); endproperty
   a_dev_cause: assert property (p_dev_cause) else $error("device drove bus unasked");
   property p_wr_gap; !wr_n |-> wr_gap_q >= NIBBLE_BUSY_CYC; endproperty
   a_wr_gap: assert property (p_wr_gap) else $error("write strobe inside busy time");
   property p_rd_gap; !rd_n |-> wr_gap_q > LONG_BUSY_CYC && rd_gap_q >= NIBBLE_BUSY_CYC; endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("read strobe inside busy time");
endmodule : rpic_monitor

/* File: sim/rpic_tb.sv */
`timescale 1ns/1ps
module rpic_tb;
   logic clk_sys;
   logic resetn;
   logic host_if_mode;
   logic req_valid;
   rpic_pkg::rpic_op_e req_op;
   logic [3:0] req_arg;
   logic [31:0] req_index;
   logic req_ready, rsp_valid, sample_tick, code_bits_4, busy;
   logic [31:0] rsp_index;
   logic [1:0] rate_sel;
   rpic_pkg::rpic_mode_e ctrl_mode;
   logic [2:0] track_num;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   int busy_cyc = 0;
   // Shortened busy counts keep the run brief; both ends and the checker must agree on them.
   localparam logic [14:0] TB_LONG_CYC = 15'h0028;
   localparam logic [14:0] TB_NIBBLE_CYC = 15'h0014;
   logic [3:0] wq[$];
   logic [3:0] rq[$];
   int dv[4] = '{1024, 768, 640, 512};
   rpic_pkg::rpic_mode_e md[4] = '{rpic_pkg::RPIC_FIXED8, rpic_pkg::RPIC_FIXED4,
      rpic_pkg::RPIC_FIXED2, rpic_pkg::RPIC_FLEX8};
   logic [2:0] tn[4] = '{3'h5, 3'h2, 3'h1, 3'h0};

   rpic_if i_rpic_if();
   rpic_device #(.LONG_BUSY_CYC(TB_LONG_CYC), .NIBBLE_BUSY_CYC(TB_NIBBLE_CYC))
      i_rpic_device (
      .clk_sys(clk_sys), .resetn(resetn), .bus(i_rpic_if), .host_if_mode(host_if_mode),
      .sample_tick(sample_tick), .rate_sel(rate_sel), .ctrl_mode(ctrl_mode),
      .track_num(track_num), .code_bits_4(code_bits_4), .busy(busy));
   rpic_host #(.LONG_BUSY_CYC(TB_LONG_CYC), .NIBBLE_BUSY_CYC(TB_NIBBLE_CYC))
      i_rpic_host (
      .clk_sys(clk_sys), .resetn(resetn), .bus(i_rpic_if), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_arg(req_arg), .req_index(req_index),
      .rsp_valid(rsp_valid), .rsp_index(rsp_index));
   rpic_monitor #(.LONG_BUSY_CYC(TB_LONG_CYC), .NIBBLE_BUSY_CYC(TB_NIBBLE_CYC))
      i_rpic_monitor (
      .clk_sys(clk_sys), .resetn(resetn), .host_dout(i_rpic_if.host_dout),
      .host_oe_n(i_rpic_if.host_oe_n), .dev_dout(i_rpic_if.dev_dout),
      .dev_oe_n(i_rpic_if.dev_oe_n), .wr_n(i_rpic_if.wr_n), .rd_n(i_rpic_if.rd_n),
      .data(i_rpic_if.data));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Nibbles seen on the wire, captured for checking the transfer order.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (i_rpic_if.wr_n === 1'b0) begin
         wq.push_back(i_rpic_if.data);
      end
      if (i_rpic_if.dev_oe_n === 1'b0) begin
         rq.push_back(i_rpic_if.data);
      end
      if (busy === 1'b1) begin
         busy_cyc <= busy_cyc + 1;
      end
      if (cyc == 95000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check

   task automatic wait_ready();
      int n;
      n = 0;
      @(negedge clk_sys);
      while (req_ready !== 1'b1 && n < 9000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 9000) begin
         err_total++;
      end
   endtask : wait_ready

   task automatic do_req(input rpic_pkg::rpic_op_e op, input logic [3:0] arg,
         input logic [31:0] idx);
      wait_ready();
      @(posedge clk_sys);
      req_op <= op;
      req_arg <= arg;
      req_index <= idx;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      wait_ready();
   endtask : do_req

   task automatic t_reset();
      @(negedge clk_sys);
      check(rate_sel, 32'h0);
      check(ctrl_mode, rpic_pkg::RPIC_DIRECT);
      check(track_num, 32'h0);
      check(code_bits_4, 32'h0);
      check(busy, 32'h0);
   endtask : t_reset

   task automatic t_rate();
      int per;
      for (int r = 0; r < 4; r++) begin
         do_req(rpic_pkg::RPIC_OP_RATE, {2'b00, r[1:0]}, 32'h0);
         check(rate_sel, r);
         per = 0;
         while (sample_tick !== 1'b1 && per < 2000) begin
            @(negedge clk_sys);
            per++;
         end
         per = 0;
         do begin
            @(negedge clk_sys);
            per++;
         end while (sample_tick !== 1'b1 && per < 2000);
         check(per, dv[r]);
      end
   endtask : t_rate

   task automatic t_modes();
      logic [11:0] share, beg, endr;
      for (int p = 0; p < 4; p++) begin
         do_req(rpic_pkg::RPIC_OP_RATE, {p[1:0], 2'b00}, 32'h0);
         do_req(rpic_pkg::RPIC_OP_TRACK, (p == 3) ? 4'h8 : 4'hD, 32'h0);
         check(ctrl_mode, md[p]);
         check(track_num, tn[p]);
         do_req(rpic_pkg::RPIC_OP_IDX_RD, 4'h0, 32'h0);
         share = 12'hFF8 >> (3 - p);
         beg = 12'h008 + 12'(share * tn[p]);
         endr = (p == 3) ? 12'hFFF : beg + share - 12'h001;
         check(rsp_index, {beg, endr, 8'hA9});
      end
      do_req(rpic_pkg::RPIC_OP_TRACK, 4'h3, 32'h0);
      check(ctrl_mode, rpic_pkg::RPIC_DIRECT);
      check(track_num, 32'h3);
   endtask : t_modes

   task automatic t_width();
      do_req(rpic_pkg::RPIC_OP_WIDTH, 4'h4, 32'h0);
      check(code_bits_4, 32'h1);
      do_req(rpic_pkg::RPIC_OP_TRACK, 4'h8, 32'h0);
      do_req(rpic_pkg::RPIC_OP_IDX_RD, 4'h0, 32'h0);
      check(rsp_index, {12'h008, 12'hFFF, 8'h7F});
      do_req(rpic_pkg::RPIC_OP_WIDTH, 4'h0, 32'h0);
      check(code_bits_4, 32'h0);
      do_req(rpic_pkg::RPIC_OP_TRACK, 4'h3, 32'h0);
   endtask : t_width

   task automatic t_index();
      logic [31:0] idx;
      int b0;
      idx = 32'h8A53C67F;
      wq.delete();
      rq.delete();
      b0 = busy_cyc;
      do_req(rpic_pkg::RPIC_OP_IDX_WR, 4'h0, idx);
      check(rsp_valid, 32'h0);
      check(busy_cyc - b0, TB_LONG_CYC + 8 * TB_NIBBLE_CYC);
      check(wq.size(), 32'h9);
      check(wq[0], rpic_pkg::CMD_IDX_WR);
      for (int k = 0; k < 8; k++) begin
         check(wq[k + 1], idx[4 * k +: 4]);
      end
      b0 = busy_cyc;
      do_req(rpic_pkg::RPIC_OP_IDX_RD, 4'h0, 32'h0);
      check(rsp_valid, 32'h1);
      check(busy_cyc - b0, TB_LONG_CYC + 8 * TB_NIBBLE_CYC);
      check(rsp_index, idx);
      check(rq.size(), 32'h8);
      for (int k = 0; k < 8; k++) begin
         check(rq[k], idx[4 * k +: 4]);
      end
   endtask : t_index

   task automatic t_hostif();
      do_req(rpic_pkg::RPIC_OP_TRACK, 4'h8, 32'h0);
      check(ctrl_mode, rpic_pkg::RPIC_FLEX8);
      @(posedge clk_sys);
      host_if_mode <= 1'b0;
      do_req(rpic_pkg::RPIC_OP_RATE, 4'hF, 32'h0);
      check(rate_sel, 32'h0);
      check(ctrl_mode, rpic_pkg::RPIC_DIRECT);
      @(posedge clk_sys);
      host_if_mode <= 1'b1;
      @(negedge clk_sys);
      check(ctrl_mode, rpic_pkg::RPIC_FLEX8);
   endtask : t_hostif

   initial begin
      resetn = 1'b0;
      host_if_mode = 1'b1;
      req_valid = 1'b0;
      req_op = rpic_pkg::RPIC_OP_RATE;
      req_arg = 4'h0;
      req_index = 32'h0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_rate();
      t_modes();
      t_width();
      t_index();
      t_hostif();
      wrap_up();
   end
endmodule : rpic_tb
